// >>> src/hsr_pkg.sv
// ----------------------------------------
// register map and field layout
// ----------------------------------------
package hsr_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int CTX_WORDS = 54;
    localparam int CTX_IDX_W = 6;
    localparam logic [ADDR_W-1:0] OFS_INT_EN = 12'h020;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h024;
    localparam logic [ADDR_W-1:0] OFS_CTX_BASE = 12'h0F8;
    localparam logic [ADDR_W-1:0] OFS_CTX_STEP = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_DIGEST6 = 12'h328;
    localparam logic [ADDR_W-1:0] OFS_DIGEST7 = 12'h32C;
    // interrupt enable fields
    localparam int BIT_INPUT_IE = 0;
    localparam int BIT_DONE_IE = 1;
    // status fields
    localparam int BIT_INPUT_FLAG = 0;
    localparam int BIT_DONE_FLAG = 1;
    localparam int BIT_DMA_ACT = 2;
    localparam int BIT_BUSY = 3;
    localparam logic [DATA_W-1:0] RST_INT_EN = 32'h0000_0000;
    localparam logic [DATA_W-1:0] RST_STATUS = 32'h0000_0001;
    localparam logic [DATA_W-1:0] RST_CTX = 32'h0000_0000;
    localparam logic [DATA_W-1:0] RST_DIGEST = 32'h0000_0000;
    // digest width selected by the core
    typedef enum logic [1:0] {
        HSR_MODE_SHORT,
        HSR_MODE_MD,
        HSR_MODE_224,
        HSR_MODE_256
    } hsr_mode_t;
    // read path states
    typedef enum logic {
        HSR_RD_IDLE,
        HSR_RD_HOLD
    } hsr_rd_state_t;
endpackage

// >>> src/hsr_regs.sv
`timescale 1ns/1ns
// Notes on behaviour
// - digest words six, seven read-only at 0x328, 0x32C
// - enable bit 1 gates completion interrupt
// - enable bit 0 gates input interrupt
// - status resets to 0x00000001
// - status bit 3 shows core busy
// - status bit 2: dma enabled or active
// - completion flag set on done, write-0 clears
// - input flag: cleared on input, set on consumed
// - 54 context words at 0xF8 plus 4x
// - saved context written back resumes core
// - digest read waits while busy; start clears
// - word six valid 224/256, seven 256 only
module hsr_regs
    import hsr_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // register port
    input wire logic [hsr_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [hsr_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [hsr_pkg::DATA_W-1:0] reg_rdata,
    output logic reg_rd_wait,
    // hash core status
    input wire logic core_busy,
    input wire logic core_done,
    input wire hsr_pkg::hsr_mode_t core_mode,
    input wire logic [hsr_pkg::DATA_W-1:0] core_digest6,
    input wire logic [hsr_pkg::DATA_W-1:0] core_digest7,
    input wire logic digest_start_clr,
    input wire logic data_in_write,
    input wire logic fifo_consumed,
    input wire logic dma_request_enable,
    input wire logic dma_xfer_active,
    // context exchange with the core
    input wire logic ctx_core_we,
    input wire logic [hsr_pkg::CTX_IDX_W-1:0] ctx_core_idx,
    input wire logic [hsr_pkg::DATA_W-1:0] ctx_core_data,
    output logic ctx_sw_we,
    output logic [hsr_pkg::CTX_IDX_W-1:0] ctx_sw_idx,
    output logic [hsr_pkg::DATA_W-1:0] ctx_sw_data,
    // interrupt
    output logic hash_irq
);
    import hsr_pkg::*;

    // ----------------------------------------
    // storage
    // ----------------------------------------
    logic [DATA_W-1:0] int_en_r;
    logic calc_done_flag_r;
    logic calc_done_flag_nxt;
    logic input_consumed_flag_r;
    logic input_consumed_flag_nxt;
    logic [DATA_W-1:0] digest6_r;
    logic [DATA_W-1:0] digest7_r;
    logic [DATA_W-1:0] ctx_r [CTX_WORDS];
    logic [DATA_W-1:0] rdata_r;
    logic [DATA_W-1:0] rdata_nxt;
    hsr_rd_state_t rd_state_r;
    hsr_rd_state_t rd_state_nxt;
    logic hold_word7_r;
    logic ctx_sw_we_r;
    logic [CTX_IDX_W-1:0] ctx_sw_idx_r;
    logic [DATA_W-1:0] ctx_sw_data_r;

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    logic [ADDR_W-1:0] ctx_off;
    logic [CTX_IDX_W-1:0] ctx_idx;
    logic hit_int_en;
    logic hit_status;
    logic hit_ctx;
    logic hit_dig6;
    logic hit_dig7;
    logic hit_digest;
    logic wr_int_en;
    logic wr_status;
    logic wr_ctx;
    logic dma_active;
    logic [DATA_W-1:0] status_word;
    logic [DATA_W-1:0] ctx_word;
    logic [DATA_W-1:0] dig_word;

    // context index is the word offset from the bank base
    assign ctx_off = reg_addr - OFS_CTX_BASE;
    assign ctx_idx = ctx_off[CTX_IDX_W+1:2];
    assign hit_int_en = (reg_addr == OFS_INT_EN);
    assign hit_status = (reg_addr == OFS_STATUS);
    assign hit_ctx = (reg_addr >= OFS_CTX_BASE) && (reg_addr[1:0] == 2'h0)
        && (ctx_off < ADDR_W'(CTX_WORDS) * OFS_CTX_STEP);
    assign hit_dig6 = (reg_addr == OFS_DIGEST6);
    assign hit_dig7 = (reg_addr == OFS_DIGEST7);
    assign hit_digest = hit_dig6 || hit_dig7;
    // digest words have no write path: writes there fall away
    assign wr_int_en = reg_wr && hit_int_en;
    assign wr_status = reg_wr && hit_status;
    assign wr_ctx = reg_wr && hit_ctx;

    // ----------------------------------------
    // status and interrupt
    // ----------------------------------------
    assign dma_active = dma_request_enable || dma_xfer_active;
    assign status_word = {28'h000_0000, core_busy, dma_active,
        calc_done_flag_r, input_consumed_flag_r};
    // any unmasked flag holds the line; only two sources exist
    assign hash_irq = (calc_done_flag_r && int_en_r[BIT_DONE_IE])
        || (input_consumed_flag_r && int_en_r[BIT_INPUT_IE]);

    // flag next values: a hardware set beats a same-cycle clear
    always_comb begin
        calc_done_flag_nxt = calc_done_flag_r;
        if (wr_status && !reg_wdata[BIT_DONE_FLAG]) begin
            calc_done_flag_nxt = 1'b0;
        end
        if (core_done) begin
            calc_done_flag_nxt = 1'b1;
        end
        input_consumed_flag_nxt = input_consumed_flag_r;
        if ((wr_status && !reg_wdata[BIT_INPUT_FLAG]) || data_in_write) begin
            input_consumed_flag_nxt = 1'b0;
        end
        if (fifo_consumed) begin
            input_consumed_flag_nxt = 1'b1;
        end
    end

    // flags and enables; reserved enable bits never store
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            int_en_r <= RST_INT_EN;
            calc_done_flag_r <= RST_STATUS[BIT_DONE_FLAG];
            input_consumed_flag_r <= RST_STATUS[BIT_INPUT_FLAG];
        end else begin
            if (wr_int_en) begin
                int_en_r <= {30'h0000_0000, reg_wdata[BIT_DONE_IE:BIT_INPUT_IE]};
            end
            calc_done_flag_r <= calc_done_flag_nxt;
            input_consumed_flag_r <= input_consumed_flag_nxt;
        end
    end

    // ----------------------------------------
    // digest words
    // ----------------------------------------
    // capture on completion; the start pulse wipes them first
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            digest6_r <= RST_DIGEST;
            digest7_r <= RST_DIGEST;
        end else if (digest_start_clr) begin
            digest6_r <= RST_DIGEST;
            digest7_r <= RST_DIGEST;
        end else if (core_done) begin
            digest6_r <= (core_mode == HSR_MODE_224 || core_mode == HSR_MODE_256)
                ? core_digest6 : RST_DIGEST;
            digest7_r <= (core_mode == HSR_MODE_256) ? core_digest7 : RST_DIGEST;
        end
    end

    // ----------------------------------------
    // context bank
    // ----------------------------------------
    // software write wins over any core update in the same cycle
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < CTX_WORDS; i++) begin
                ctx_r[i] <= RST_CTX;
            end
        end else if (wr_ctx) begin
            ctx_r[ctx_idx] <= reg_wdata;
        end else if (ctx_core_we && (int'(ctx_core_idx) < CTX_WORDS)) begin
            ctx_r[ctx_core_idx] <= ctx_core_data;
        end
    end

    // restored words are forwarded so the core can resume
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ctx_sw_we_r <= 1'b0;
            ctx_sw_idx_r <= '0;
            ctx_sw_data_r <= RST_CTX;
        end else begin
            ctx_sw_we_r <= wr_ctx;
            if (wr_ctx) begin
                ctx_sw_idx_r <= ctx_idx;
                ctx_sw_data_r <= reg_wdata;
            end
        end
    end
    assign ctx_sw_we = ctx_sw_we_r;
    assign ctx_sw_idx = ctx_sw_idx_r;
    assign ctx_sw_data = ctx_sw_data_r;

    // ----------------------------------------
    // read path
    // ----------------------------------------
    assign ctx_word = hit_ctx ? ctx_r[ctx_idx] : RST_CTX;
    assign dig_word = hold_word7_r ? digest7_r : digest6_r;

    // a digest read during a calculation is held until the
    // result is captured; the master must watch reg_rd_wait
    always_comb begin
        rd_state_nxt = rd_state_r;
        rdata_nxt = '0;
        case (rd_state_r)
            HSR_RD_IDLE: begin
                if (reg_rd && hit_digest && core_busy) begin
                    rd_state_nxt = HSR_RD_HOLD;
                end else if (reg_rd) begin
                    if (hit_int_en) rdata_nxt = int_en_r;
                    else if (hit_status) rdata_nxt = status_word;
                    else if (hit_ctx) rdata_nxt = ctx_word;
                    else if (hit_dig6) rdata_nxt = digest6_r;
                    else if (hit_dig7) rdata_nxt = digest7_r;
                end
            end
            HSR_RD_HOLD: begin
                if (!core_busy && !core_done) begin
                    rd_state_nxt = HSR_RD_IDLE;
                    rdata_nxt = dig_word;
                end
            end
            default: begin
                rd_state_nxt = HSR_RD_IDLE;
            end
        endcase
    end

    // read data stands for one cycle only
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rd_state_r <= HSR_RD_IDLE;
            rdata_r <= '0;
            hold_word7_r <= 1'b0;
        end else begin
            rd_state_r <= rd_state_nxt;
            rdata_r <= rdata_nxt;
            if (rd_state_r == HSR_RD_IDLE && reg_rd) begin
                hold_word7_r <= hit_dig7;
            end
        end
    end
    assign reg_rdata = rdata_r;
    assign reg_rd_wait = (rd_state_r == HSR_RD_HOLD);

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence s_done_seen;
        core_done && !digest_start_clr;
    endsequence
    sequence s_flag_up;
        ##1 calc_done_flag_r;
    endsequence
    property p_done_sets_flag;
        @(posedge sys_clk) disable iff (!nrst) s_done_seen |-> s_flag_up;
    endproperty
    a_done_sets_flag: assert property (p_done_sets_flag)
        else $error("completion flag not set after done");

    property p_flag_write1_keeps;
        @(posedge sys_clk) disable iff (!nrst)
            (calc_done_flag_r && wr_status && reg_wdata[BIT_DONE_FLAG]) |=> calc_done_flag_r;
    endproperty
    a_flag_write1_keeps: assert property (p_flag_write1_keeps)
        else $error("writing one cleared completion flag");

    property p_input_clear;
        @(posedge sys_clk) disable iff (!nrst)
            (data_in_write && !fifo_consumed) |=> !input_consumed_flag_r;
    endproperty
    a_input_clear: assert property (p_input_clear)
        else $error("input flag not cleared on data write");

    property p_input_set;
        @(posedge sys_clk) disable iff (!nrst) fifo_consumed |=> input_consumed_flag_r;
    endproperty
    a_input_set: assert property (p_input_set)
        else $error("input flag not set on fifo consumed");

    property p_irq_done;
        @(posedge sys_clk) disable iff (!nrst)
            (calc_done_flag_r && int_en_r[BIT_DONE_IE]) |-> hash_irq;
    endproperty
    a_irq_done: assert property (p_irq_done)
        else $error("completion interrupt missing");

    property p_irq_masked;
        @(posedge sys_clk) disable iff (!nrst)
            (int_en_r[BIT_DONE_IE:BIT_INPUT_IE] == 2'h0) |-> !hash_irq;
    endproperty
    a_irq_masked: assert property (p_irq_masked)
        else $error("interrupt raised while masked");

    property p_status_read;
        @(posedge sys_clk) disable iff (!nrst)
            (reg_rd && hit_status && rd_state_r == HSR_RD_IDLE)
            |=> reg_rdata[BIT_BUSY:BIT_DMA_ACT] == {$past(core_busy), $past(dma_active)};
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("busy or dma bit read wrong");

    property p_word7_mode;
        @(posedge sys_clk) disable iff (!nrst)
            (core_done && !digest_start_clr && core_mode != HSR_MODE_256)
            |=> digest7_r == RST_DIGEST;
    endproperty
    a_word7_mode: assert property (p_word7_mode)
        else $error("word seven loaded outside 256 mode");

    property p_start_clears;
        @(posedge sys_clk) disable iff (!nrst)
            digest_start_clr |=> (digest6_r == RST_DIGEST) && (digest7_r == RST_DIGEST);
    endproperty
    a_start_clears: assert property (p_start_clears)
        else $error("start did not clear digest");

    property p_busy_read_holds;
        @(posedge sys_clk) disable iff (!nrst)
            (reg_rd && hit_digest && core_busy && rd_state_r == HSR_RD_IDLE)
            |=> reg_rd_wait;
    endproperty
    a_busy_read_holds: assert property (p_busy_read_holds)
        else $error("digest read not held while busy");

    property p_ctx_forward;
        @(posedge sys_clk) disable iff (!nrst)
            wr_ctx |=> ctx_sw_we && ctx_sw_data == $past(reg_wdata)
                && ctx_r[ctx_sw_idx] == ctx_sw_data;
    endproperty
    a_ctx_forward: assert property (p_ctx_forward)
        else $error("context write not stored or forwarded");
endmodule

// >>> bench/test_hash_unit_status_context_regs.sv
`timescale 1ns/1ns
module test_hash_unit_status_context_regs;
    import hsr_pkg::*;
    // ----
    // stimulus and observed signals
    // ----
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    logic reg_rd_wait;
    logic core_busy = 1'b0;
    logic dma_request_enable = 1'b0;
    logic dma_xfer_active = 1'b0;
    logic [4:0] ev = '0; // done, start clear, input write, consumed, core ctx write
    hsr_mode_t core_mode = HSR_MODE_SHORT;
    logic [DATA_W-1:0] core_digest6 = '0;
    logic [DATA_W-1:0] core_digest7 = '0;
    logic [CTX_IDX_W-1:0] ctx_core_idx = '0;
    logic [DATA_W-1:0] ctx_core_data = '0;
    logic ctx_sw_we;
    logic [CTX_IDX_W-1:0] ctx_sw_idx;
    logic [DATA_W-1:0] ctx_sw_data;
    logic hash_irq;
    int errors = 0;
    int checked = 0;
    int cyc = 0;
    integer seed = 82;
    // reference model state
    int unsigned m_en = 0;
    int unsigned m_d6 = 0;
    int unsigned m_d7 = 0;
    int unsigned m_ctx[54];
    int unsigned r6;
    int unsigned r7;
    bit m_done = 0;
    bit m_in = 1;

    hsr_regs dut (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rd_wait(reg_rd_wait),
        .core_busy(core_busy), .core_done(ev[0]), .core_mode(core_mode),
        .core_digest6(core_digest6), .core_digest7(core_digest7), .digest_start_clr(ev[1]),
        .data_in_write(ev[2]), .fifo_consumed(ev[3]), .dma_request_enable(dma_request_enable),
        .dma_xfer_active(dma_xfer_active), .ctx_core_we(ev[4]), .ctx_core_idx(ctx_core_idx),
        .ctx_core_data(ctx_core_data), .ctx_sw_we(ctx_sw_we), .ctx_sw_idx(ctx_sw_idx),
        .ctx_sw_data(ctx_sw_data), .hash_irq(hash_irq));

    // ----
    // clock, hang guard, helpers
    // ----
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end

    // far above the few hundred cycles the sequence needs
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            close_out();
        end
    end

    task automatic close_out();
        $display("checks %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one-cycle strobes, launched right after a rising edge
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    // data stand only in the cycle after the strobe, so sample there
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string name);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        chk(name, reg_rdata, exp);
    endtask

    task automatic pulse(input int k);
        @(posedge sys_clk);
        ev[k] <= 1'b1;
        @(posedge sys_clk);
        ev <= '0;
    endtask

    // status with busy and dma lines low
    function automatic logic [31:0] st();
        return {30'h0, m_done, m_in};
    endfunction

    task automatic chk_irq();
        @(negedge sys_clk);
        chk("hash_irq", 32'(hash_irq), 32'((m_done & m_en[1]) | (m_in & m_en[0])));
    endtask

    // ----
    // main sequence
    // ----
    initial begin
        repeat (20) @(posedge sys_clk);
        nrst <= 1'b1;
        rd(OFS_STATUS, st(), "status");
        rd(OFS_INT_EN, 32'h0, "int_en");
        rd(OFS_CTX_BASE + 12'h0D4, 32'h0, "ctx53");
        rd(12'h000, 32'h0, "unmapped");
        // software keeps reserved enable bits at zero
        wr(OFS_INT_EN, 32'h0000_0003);
        m_en = 3;
        rd(OFS_INT_EN, m_en, "int_en");
        chk_irq();
        wr(OFS_INT_EN, 32'h2);
        m_en = 2;
        chk_irq();
        pulse(2);
        m_in = 0;
        rd(OFS_STATUS, st(), "status");
        pulse(3);
        m_in = 1;
        rd(OFS_STATUS, st(), "status");
        wr(OFS_STATUS, 32'h0);
        m_in = 0;
        rd(OFS_STATUS, st(), "status");
        // every combination of busy and the two dma lines
        for (int k = 0; k < 8; k++) begin
            @(posedge sys_clk);
            {core_busy, dma_request_enable, dma_xfer_active} <= 3'(k);
            rd(OFS_STATUS, {28'h0, k[2], k[1] | k[0], m_done, m_in}, "status");
        end
        @(posedge sys_clk);
        {core_busy, dma_request_enable, dma_xfer_active} <= 3'h0;
        // every mode; 224 loads word six, 256 loads both, the other two neither
        for (int m = 0; m < 4; m++) begin
            r6 = $random(seed);
            r7 = $random(seed);
            @(posedge sys_clk);
            core_mode <= hsr_mode_t'(m);
            core_digest6 <= r6;
            core_digest7 <= r7;
            pulse(0);
            m_d6 = (m >= 2) ? r6 : 0;
            m_d7 = (m == 3) ? r7 : 0;
            m_done = 1;
            rd(OFS_DIGEST6, m_d6, "digest6");
            rd(OFS_DIGEST7, m_d7, "digest7");
            rd(OFS_STATUS, st(), "status");
            chk_irq();
        end
        wr(OFS_DIGEST6, 32'hFFFF_FFFF);
        rd(OFS_DIGEST6, m_d6, "digest6");
        // digest read while busy is held until the core goes idle
        @(posedge sys_clk);
        core_busy <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= OFS_DIGEST7;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        chk("reg_rd_wait", 32'(reg_rd_wait), 32'h1);
        repeat (3) @(posedge sys_clk);
        core_busy <= 1'b0;
        for (int i = 0; i < 8 && reg_rd_wait !== 1'b0; i++) @(negedge sys_clk);
        chk("reg_rd_wait", 32'(reg_rd_wait), 32'h0);
        chk("digest7", reg_rdata, m_d7);
        wr(OFS_INT_EN, 32'h1);
        m_en = 1;
        chk_irq();
        wr(OFS_STATUS, 32'h3);
        rd(OFS_STATUS, st(), "status");
        wr(OFS_STATUS, 32'h1);
        m_done = 0;
        rd(OFS_STATUS, st(), "status");
        pulse(1);
        rd(OFS_DIGEST6, 32'h0, "digest6");
        rd(OFS_DIGEST7, 32'h0, "digest7");
        // save and restore the whole context bank
        for (int i = 0; i < CTX_WORDS; i++) begin
            m_ctx[i] = $random(seed);
            wr(OFS_CTX_BASE + 12'(4 * i), m_ctx[i]);
            @(negedge sys_clk);
            chk("ctx_sw_we", 32'(ctx_sw_we), 32'h1);
            chk("ctx_sw_idx", 32'(ctx_sw_idx), i);
            chk("ctx_sw_data", ctx_sw_data, m_ctx[i]);
        end
        r6 = $random(seed);
        @(posedge sys_clk);
        ctx_core_idx <= 6'd7;
        ctx_core_data <= r6;
        pulse(4);
        m_ctx[7] = r6;
        for (int i = 0; i < CTX_WORDS; i++) begin
            rd(OFS_CTX_BASE + 12'(4 * i), m_ctx[i], "ctx");
        end
        rd(OFS_CTX_BASE + 12'h001, 32'h0, "ctx_unaligned");
        // second reset in mid-run restores defaults
        @(posedge sys_clk);
        nrst <= 1'b0;
        repeat (3) @(posedge sys_clk);
        nrst <= 1'b1;
        m_in = 1;
        m_en = 0;
        rd(OFS_STATUS, st(), "status");
        rd(OFS_CTX_BASE + 12'h01C, 32'h0, "ctx7");
        rd(OFS_INT_EN, 32'h0, "int_en");
        close_out();
    end
endmodule
